// ---- verilog/frl_defs.svh ----
/*
 * Constants of the flash row latch block: address map, field positions,
 * erase values and checksum masks.
 * Assumes inclusion by bare name from both ends and the bench.
 */
`ifndef FRL_DEFS_SVH
`define FRL_DEFS_SVH

// ****************************************
// Address map
// ****************************************
`define FRL_CFG_BASE 16'h8000
`define FRL_PROG_TOP 16'h7fff
`define FRL_ADDR_TOP 16'hffff
`define FRL_UID_LAST 16'h8003
`define FRL_DEVID_ADDR 16'h8006
`define FRL_CFG1_ADDR 16'h8007
`define FRL_CFG2_ADDR 16'h8008
`define FRL_CAL_FIRST 16'h8009
`define FRL_CAL_LAST 16'h800b
`define FRL_CFG1_IDX 4'h7
`define FRL_CFG2_IDX 4'h8
`define FRL_UID_COUNT 4

// ****************************************
// Fields and values
// ****************************************
`define FRL_WORD_W 14
`define FRL_ERASED 14'h3fff
`define FRL_CP_BIT 7
`define FRL_CFG1_MASK 14'h0efb
`define FRL_CFG2_MASK 14'h3f07
`define FRL_LATCHES 32
`define FRL_PROG_WORDS 1024

`endif

// ---- verilog/frl_pkg.sv ----
/*
 * Types shared by both ends of the flash row latch link.
 * Assumes frl_defs.svh for numeric constants.
 */
package frl_pkg;

   typedef enum logic [3:0] {
      FRL_CMD_LOAD_CFG = 4'h0,
      FRL_CMD_LOAD_DATA = 4'h1,
      FRL_CMD_READ = 4'h2,
      FRL_CMD_INC_ADDR = 4'h3,
      FRL_CMD_RESET_ADDR = 4'h4,
      FRL_CMD_BEGIN_INT = 4'h5,
      FRL_CMD_BEGIN_EXT = 4'h6,
      FRL_CMD_END_EXT = 4'h7,
      FRL_CMD_BULK_ERASE = 4'h8,
      FRL_CMD_ROW_ERASE = 4'h9
   } frl_cmd_e;

   typedef enum logic [3:0] {
      FRL_ST_IDLE = 4'b0001,
      FRL_ST_WRITE = 4'b0010,
      FRL_ST_ERASE = 4'b0100,
      FRL_ST_EXT = 4'b1000
   } frl_state_e;

   typedef logic [13:0] frl_word_t;

endpackage : frl_pkg

// ---- verilog/frl_link_if.sv ----
/*
 * Command link between the programmer end and the flash device end.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface frl_link_if;
   import frl_pkg::*;
   logic cmd_valid;
   logic cmd_ready;
   frl_cmd_e cmd_code;
   frl_word_t cmd_data;
   logic rsp_valid;
   frl_word_t rsp_data;

   modport device (input cmd_valid, input cmd_code, input cmd_data,
                   output cmd_ready, output rsp_valid, output rsp_data);
   modport programmer (output cmd_valid, output cmd_code, output cmd_data,
                       input cmd_ready, input rsp_valid, input rsp_data);
endinterface : frl_link_if

// ---- verilog/frl_device.sv ----
/*
 * Flash device end: address counter, row write latches, program and
 * configuration memory, code protection and erase sequencing.
 * Assumes the programmer keeps the link handshake; firmware port on same clock.
 */
// Overview of operation
// - Latches hold fourteen-bit words until commit
// - Each load fills one latch, kept
// - Low address bits select the latch
// - High address bits select the row
// - Program commit writes every latch into row; config commit writes one word
// - Commit never spans two rows
// - Extra loads overwrite same latch position
// - Protected program memory reads as zero
// - Protected program memory refuses programming
// - Firmware access ignores code protection
// - User IDs, config words ignore protection
// - Protection on when protect bit zero
// - Bulk erase, or a config word 1 write with protect bit one, clears protection
// - Externally timed config writes are ignored
// - Erase leaves calibration words intact
// - Image stores words low byte first
// - Programmer warns on identifier mismatch
// - Unprotected checksum sums program and config
// - Config words masked before summing
// - Checksum nibbles placed in user IDs
// - Protected checksum built from ID nibbles
// - Thirty-two latches, thirty-two word rows
// - Protected part ignores program row erase
`timescale 1ns/1ps
`include "frl_defs.svh"

module frl_device
   import frl_pkg::*;
#(
   parameter int LATCHES = `FRL_LATCHES,
   parameter int PROG_WORDS = `FRL_PROG_WORDS
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Programmer link
   frl_link_if.device link,
   // Firmware access to program memory
   input wire logic fw_we_in,
   input wire logic [$clog2(PROG_WORDS)-1:0] fw_addr_in,
   input wire frl_word_t fw_wdata_in,
   output frl_word_t fw_rdata_out,
   // Status
   output logic busy_out,
   output logic protected_out
);

   localparam int LW = $clog2(LATCHES);
   localparam int PW = $clog2(PROG_WORDS);
   localparam logic [15:0] CFG_BASE = `FRL_CFG_BASE;

   // ****************************************
   // Elaboration checks
   // ****************************************
   if (LATCHES != (1 << LW) || PROG_WORDS != (1 << PW) || PW <= LW || PW > 15) begin : g_bad
      $error("frl_device: sizes must be powers of two, rows inside program space");
   end

   // ****************************************
   // State
   // ****************************************
   frl_state_e state_q, state_d;
   logic [15:0] addr_q, addr_d;
   frl_word_t latch_q [LATCHES];
   frl_word_t prog_mem [PROG_WORDS];
   frl_word_t cfg_q [16];
   logic [PW-1:0] ptr_q, ptr_d;
   logic [PW-1:0] end_q, end_d;
   logic ready_q;
   logic rsp_valid_q;
   frl_word_t rsp_data_q;
   frl_word_t fw_rdata_q;

   // ****************************************
   // Decode
   // ****************************************
   wire take = link.cmd_valid & ready_q;
   wire in_prog = ~addr_q[15];
   wire cp_on = ~cfg_q[`FRL_CFG1_IDX][`FRL_CP_BIT];
   wire [LW-1:0] lidx = addr_q[LW-1:0];
   wire [PW-LW-1:0] row = addr_q[PW-1:LW];
   wire in_uid_zone = addr_q >= `FRL_CFG_BASE && addr_q <= `FRL_CFG2_ADDR;
   wire cfg_slot = addr_q[15:4] == CFG_BASE[15:4];
   wire is_load = take && (link.cmd_code == FRL_CMD_LOAD_DATA || link.cmd_code == FRL_CMD_LOAD_CFG);
   wire [LW-1:0] load_idx = link.cmd_code == FRL_CMD_LOAD_CFG ? '0 : lidx;
   wire idle = state_q == FRL_ST_IDLE;
   wire begin_int = take && idle && link.cmd_code == FRL_CMD_BEGIN_INT;
   wire end_ext = take && state_q == FRL_ST_EXT && link.cmd_code == FRL_CMD_END_EXT;
   wire prog_commit = (begin_int | end_ext) && in_prog && !cp_on;
   wire cfg_commit = begin_int && cfg_slot;
   wire bulk = take && idle && link.cmd_code == FRL_CMD_BULK_ERASE;
   wire row_erase = take && idle && link.cmd_code == FRL_CMD_ROW_ERASE;
   wire row_prog = row_erase && in_prog && !cp_on;
   wire uid_erase = (bulk && addr_q[15]) || (row_erase && in_uid_zone);
   wire seq_run = state_q == FRL_ST_WRITE || state_q == FRL_ST_ERASE;
   wire [15:0] addr_inc = addr_q == `FRL_PROG_TOP ? 16'h0000 :
                          addr_q == `FRL_ADDR_TOP ? `FRL_CFG_BASE : addr_q + 16'h0001;
   wire frl_word_t rd_word = in_prog ? (cp_on ? '0 : prog_mem[addr_q[PW-1:0]]) : cfg_q[addr_q[3:0]];
   wire frl_word_t rd_out = !in_prog && !cfg_slot ? '0 : rd_word;
   wire [PW-1:0] row_base = {row, {LW{1'b0}}};

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      ptr_d = ptr_q;
      end_d = end_q;
      if (take) begin
         case (link.cmd_code)
            FRL_CMD_LOAD_CFG: addr_d = `FRL_CFG_BASE;
            FRL_CMD_INC_ADDR: addr_d = addr_inc;
            FRL_CMD_RESET_ADDR: addr_d = 16'h0000;
            default: addr_d = addr_q;
         endcase
      end
      case (state_q)
         FRL_ST_IDLE: begin
            if (take && link.cmd_code == FRL_CMD_BEGIN_EXT) begin
               state_d = FRL_ST_EXT;
            end else if (prog_commit) begin
               // Row fixed by the address at commit time
               state_d = FRL_ST_WRITE;
               ptr_d = row_base;
               end_d = row_base + PW'(LATCHES - 1);
            end else if (bulk) begin
               state_d = FRL_ST_ERASE;
               ptr_d = '0;
               end_d = PW'(PROG_WORDS - 1);
            end else if (row_prog) begin
               state_d = FRL_ST_ERASE;
               ptr_d = row_base;
               end_d = row_base + PW'(LATCHES - 1);
            end
         end
         FRL_ST_EXT: begin
            if (end_ext) begin
               state_d = prog_commit ? FRL_ST_WRITE : FRL_ST_IDLE;
               ptr_d = row_base;
               end_d = row_base + PW'(LATCHES - 1);
            end
         end
         FRL_ST_WRITE, FRL_ST_ERASE: begin
            ptr_d = ptr_q + PW'(1);
            if (ptr_q == end_q) begin
               state_d = FRL_ST_IDLE;
            end
         end
         default: state_d = FRL_ST_IDLE;
      endcase
   end

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_q <= FRL_ST_IDLE;
         addr_q <= 16'h0000;
         ptr_q <= '0;
         end_q <= '0;
         ready_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_data_q <= '0;
      end else begin
         state_q <= state_d;
         addr_q <= addr_d;
         ptr_q <= ptr_d;
         end_q <= end_d;
         // Gap cycle after each command keeps spacing simple
         ready_q <= !take && (state_d == FRL_ST_IDLE || state_d == FRL_ST_EXT);
         rsp_valid_q <= take && link.cmd_code == FRL_CMD_READ;
         if (take && link.cmd_code == FRL_CMD_READ) begin
            rsp_data_q <= rd_out;
         end
      end
   end

   // ****************************************
   // Write latches
   // ****************************************
   for (genvar i = 0; i < LATCHES; i++) begin : g_latch
      always_ff @(posedge clk_in) begin
         if (reset_in) begin
            latch_q[i] <= `FRL_ERASED;
         end else if (is_load && load_idx == LW'(i)) begin
            latch_q[i] <= link.cmd_data;
         end
      end
   end

   // ****************************************
   // Program memory
   // ****************************************
   // Firmware writes are dropped while a sequence owns the array
   always_ff @(posedge clk_in) begin
      if (state_q == FRL_ST_WRITE) begin
         prog_mem[ptr_q] <= latch_q[ptr_q[LW-1:0]];
      end else if (state_q == FRL_ST_ERASE) begin
         prog_mem[ptr_q] <= `FRL_ERASED;
      end else if (fw_we_in) begin
         prog_mem[fw_addr_in] <= fw_wdata_in;
      end
      fw_rdata_q <= prog_mem[fw_addr_in];
   end

   // ****************************************
   // Configuration memory
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         for (int k = 0; k < 16; k++) begin
            cfg_q[k] <= `FRL_ERASED;
         end
      end else begin
         if (cfg_commit) begin
            cfg_q[addr_q[3:0]] <= latch_q[lidx];
         end
         if (bulk) begin
            cfg_q[`FRL_CFG1_IDX] <= `FRL_ERASED;
            cfg_q[`FRL_CFG2_IDX] <= `FRL_ERASED;
         end
         if (uid_erase) begin
            // Calibration slots lie outside this range
            for (int k = 0; k < `FRL_UID_COUNT; k++) begin
               cfg_q[k] <= `FRL_ERASED;
            end
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         busy_out <= 1'b0;
         protected_out <= 1'b0;
         fw_rdata_out <= '0;
      end else begin
         busy_out <= state_d != FRL_ST_IDLE;
         protected_out <= cp_on;
         fw_rdata_out <= fw_rdata_q;
      end
   end

   assign link.cmd_ready = ready_q;
   assign link.rsp_valid = rsp_valid_q;
   assign link.rsp_data = rsp_data_q;

endmodule : frl_device

// ---- verilog/frl_programmer.sv ----
/*
 * Programmer end: forwards user commands over the link, mirrors the
 * address counter and builds image bytes, identifier check and checksums.
 * Assumes the device end keeps the link handshake.
 */
`timescale 1ns/1ps
`include "frl_defs.svh"

module frl_programmer
   import frl_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // User command port
   input wire logic op_valid_in,
   input wire frl_cmd_e op_code_in,
   input wire frl_word_t op_data_in,
   output logic op_ready_out,
   input wire logic cks_clear_in,
   input wire frl_word_t expected_id_in,
   // Read results
   output logic rd_valid_out,
   output logic [16:0] img_addr_out,
   output logic [7:0] img_lo_out,
   output logic [7:0] img_hi_out,
   output logic id_mismatch_out,
   // Checksums
   output logic [15:0] cks_open_out,
   output logic [15:0] cks_prot_out,
   output logic [55:0] uid_words_out,
   // Link
   frl_link_if.programmer link
);

   logic valid_q;
   frl_cmd_e code_q;
   frl_word_t data_q;
   logic [15:0] addr_q;
   logic [15:0] prog_sum_q;
   logic [15:0] cfg_sum_q;
   logic [15:0] id_val_q;

   // ****************************************
   // Decode
   // ****************************************
   wire sent = valid_q & link.cmd_ready;
   wire accept = op_valid_in & op_ready_out;
   wire [15:0] addr_inc = addr_q == `FRL_PROG_TOP ? 16'h0000 :
                          addr_q == `FRL_ADDR_TOP ? `FRL_CFG_BASE : addr_q + 16'h0001;
   wire [15:0] rword = {2'b00, link.rsp_data};
   wire is_uid = addr_q >= `FRL_CFG_BASE && addr_q <= `FRL_UID_LAST;
   wire [15:0] cks_open_d = prog_sum_q + cfg_sum_q;
   wire [15:0] cks_prot_d = id_val_q + cfg_sum_q;

   // ****************************************
   // Command forwarding
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         valid_q <= 1'b0;
         code_q <= FRL_CMD_READ;
         data_q <= '0;
         op_ready_out <= 1'b0;
         addr_q <= 16'h0000;
      end else begin
         if (accept) begin
            valid_q <= 1'b1;
            code_q <= op_code_in;
            data_q <= op_data_in;
         end else if (sent) begin
            valid_q <= 1'b0;
         end
         op_ready_out <= !accept && (!valid_q || sent);
         if (sent) begin
            case (code_q)
               FRL_CMD_LOAD_CFG: addr_q <= `FRL_CFG_BASE;
               FRL_CMD_INC_ADDR: addr_q <= addr_inc;
               FRL_CMD_RESET_ADDR: addr_q <= 16'h0000;
               default: addr_q <= addr_q;
            endcase
         end
      end
   end

   // ****************************************
   // Read results and checksums
   // ****************************************
   // Reads complete before the next command leaves, so addr_q still names them
   always_ff @(posedge clk_in) begin
      if (reset_in || cks_clear_in) begin
         prog_sum_q <= 16'h0000;
         cfg_sum_q <= 16'h0000;
         id_val_q <= 16'h0000;
         rd_valid_out <= 1'b0;
         img_addr_out <= '0;
         img_lo_out <= 8'h00;
         img_hi_out <= 8'h00;
         id_mismatch_out <= 1'b0;
      end else begin
         rd_valid_out <= link.rsp_valid;
         if (link.rsp_valid) begin
            img_addr_out <= {addr_q, 1'b0};
            img_lo_out <= link.rsp_data[7:0];
            img_hi_out <= {2'b00, link.rsp_data[13:8]};
            if (!addr_q[15]) begin
               prog_sum_q <= prog_sum_q + rword;
            end
            if (addr_q == `FRL_CFG1_ADDR) begin
               cfg_sum_q <= cfg_sum_q + {2'b00, link.rsp_data & `FRL_CFG1_MASK};
            end
            if (addr_q == `FRL_CFG2_ADDR) begin
               cfg_sum_q <= cfg_sum_q + {2'b00, link.rsp_data & `FRL_CFG2_MASK};
            end
            if (is_uid) begin
               id_val_q[15 - 4 * addr_q[1:0] -: 4] <= link.rsp_data[3:0];
            end
            if (addr_q == `FRL_DEVID_ADDR) begin
               id_mismatch_out <= link.rsp_data != expected_id_in;
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cks_open_out <= 16'h0000;
         cks_prot_out <= 16'h0000;
         uid_words_out <= '0;
      end else begin
         cks_open_out <= cks_open_d;
         cks_prot_out <= cks_prot_d;
         // First user ID gets the top nibble
         uid_words_out <= {10'h000, cks_open_d[15:12], 10'h000, cks_open_d[11:8],
                           10'h000, cks_open_d[7:4], 10'h000, cks_open_d[3:0]};
      end
   end

   assign link.cmd_valid = valid_q;
   assign link.cmd_code = code_q;
   assign link.cmd_data = data_q;

endmodule : frl_programmer

// ---- sim/frl_link_properties.sv ----
/*
 * Concurrent checks on the link between programmer and device ends.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module frl_link_properties
   import frl_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Link
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire frl_cmd_e cmd_code,
   input wire frl_word_t cmd_data,
   input wire logic rsp_valid,
   input wire frl_word_t rsp_data
);
   // ****************************************
   // Handshake and answer timing
   // ****************************************
   wire take = cmd_valid && cmd_ready;
   wire take_rd = take && (cmd_code == FRL_CMD_READ);

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   a_read_answer: assert property (take_rd |=> rsp_valid)
      else $error("read not answered one cycle after take");
   a_no_stray: assert property (rsp_valid |-> $past(take_rd))
      else $error("answer without a read");
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer longer than one cycle");
   a_rsp_held: assert property (!rsp_valid |-> $stable(rsp_data))
      else $error("read word changed without a read");
   a_ready_gap: assert property (take |=> !cmd_ready)
      else $error("ready not dropped after take");
   a_ready_back: assert property (take |-> ##[2:200] cmd_ready)
      else $error("ready not back in time");
   a_hold_cmd: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_code) && $stable(cmd_data))
      else $error("command changed before take");
   a_cmd_served: assert property (cmd_valid |-> ##[0:300] cmd_ready)
      else $error("command never taken");
endmodule : frl_link_properties

// ---- sim/test_flash_row_latch_write_and_code_protect.sv ----
/*
 * Bench joining programmer and device ends, checked against a model.
 * Assumes frl_pkg, frl_defs.svh and frl_link_if compiled first.
 */
`timescale 1ns/1ps
`include "frl_defs.svh"
module test_flash_row_latch_write_and_code_protect
   import frl_pkg::*;
;
   logic clk_in = 0, reset_in = 1, op_valid_in = 0, cks_clear_in = 0, fw_we_in = 0;
   frl_cmd_e op_code_in = FRL_CMD_READ;
   frl_word_t op_data_in = '0, fw_wdata_in = '0, fw_rdata_out, exp_id = '0;
   logic [5:0] fw_addr_in = '0;
   logic op_ready_out, rd_valid_out, id_mismatch_out, busy_out, protected_out;
   logic [16:0] img_addr_out;
   logic [7:0] img_lo_out, img_hi_out;
   logic [15:0] cks_open_out, cks_prot_out, cks, cfs, pid;
   logic [55:0] uid_words_out;
   int bad_count = 0, num_checks = 0, adr, ma, me;
   frl_word_t lat [32], pm [64], cfg [16];
   int q [$];

   always #10 clk_in = ~clk_in;

   frl_link_if link();
   frl_programmer frl_programmer_inst (.clk_in(clk_in), .reset_in(reset_in), .op_valid_in(op_valid_in),
      .op_code_in(op_code_in), .op_data_in(op_data_in), .op_ready_out(op_ready_out),
      .cks_clear_in(cks_clear_in), .expected_id_in(exp_id), .rd_valid_out(rd_valid_out),
      .img_addr_out(img_addr_out), .img_lo_out(img_lo_out), .img_hi_out(img_hi_out),
      .id_mismatch_out(id_mismatch_out), .cks_open_out(cks_open_out), .cks_prot_out(cks_prot_out),
      .uid_words_out(uid_words_out), .link(link));
   frl_device #(.LATCHES(32), .PROG_WORDS(64)) frl_device_inst (.clk_in(clk_in), .reset_in(reset_in),
      .link(link), .fw_we_in(fw_we_in), .fw_addr_in(fw_addr_in), .fw_wdata_in(fw_wdata_in),
      .fw_rdata_out(fw_rdata_out), .busy_out(busy_out), .protected_out(protected_out));
   frl_link_properties frl_link_properties_inst (.clk_in(clk_in), .reset_in(reset_in),
      .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd_code(link.cmd_code),
      .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));

   // ****************************************
   // Checking and model
   // ****************************************
   task automatic chk(input string n, input logic [55:0] e, input logic [55:0] s);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   function automatic frl_word_t rdx(input int a);
      if (a < 'h8000) return cfg[7][7] ? pm[a % 64] : 14'h0000;
      return a < 'h8010 ? cfg[a % 16] : 14'h0000;
   endfunction : rdx

   // Commit lands in the row of the current address only
   task automatic commit(input bit internal);
      if (adr < 'h8000) begin
         if (cfg[7][7]) for (int k = 0; k < 32; k++) pm[(adr & 'h20) + k] = lat[k];
      end else if (internal && adr < 'h8010) cfg[adr % 16] = lat[adr % 32];
   endtask : commit

   task automatic op(input frl_cmd_e c, input frl_word_t d);
      int n;
      frl_word_t e;
      n = 0;
      @(posedge clk_in);
      op_valid_in <= 1'b1;
      op_code_in <= c;
      op_data_in <= d;
      do begin
         @(posedge clk_in);
         n++;
      end while (op_ready_out !== 1'b1 && n < 300);
      op_valid_in <= 1'b0;
      if (op_ready_out !== 1'b1) chk("op_ready", 1, op_ready_out);
      case (c)
         FRL_CMD_LOAD_CFG: begin
            adr = 'h8000;
            lat[0] = d;
         end
         FRL_CMD_LOAD_DATA: lat[adr % 32] = d;
         FRL_CMD_READ: begin
            e = rdx(adr);
            q.push_back(adr);
            q.push_back(e);
            if (adr < 'h8000) cks += e;
            else if (adr == 'h8007) cfs += e & 14'h0efb;
            else if (adr == 'h8008) cfs += e & 14'h3f07;
            else if (adr < 'h8004) pid[15 - 4 * (adr % 4) -: 4] = e[3:0];
         end
         FRL_CMD_INC_ADDR: adr = adr == 'h7fff ? 0 : adr == 'hffff ? 'h8000 : adr + 1;
         FRL_CMD_RESET_ADDR: adr = 0;
         FRL_CMD_BEGIN_INT: commit(1);
         FRL_CMD_END_EXT: commit(0);
         FRL_CMD_BULK_ERASE: begin
            foreach (pm[k]) pm[k] = 14'h3fff;
            cfg[7] = 14'h3fff;
            cfg[8] = 14'h3fff;
            if (adr >= 'h8000) for (int k = 0; k < 4; k++) cfg[k] = 14'h3fff;
         end
         FRL_CMD_ROW_ERASE: begin
            if (adr < 'h8000 && cfg[7][7]) for (int k = 0; k < 32; k++) pm[(adr & 'h20) + k] = 14'h3fff;
            else if (adr >= 'h8000 && adr <= 'h8008) for (int k = 0; k < 4; k++) cfg[k] = 14'h3fff;
         end
         default: ;
      endcase
      repeat (4) @(posedge clk_in);
      n = 0;
      while (c != FRL_CMD_BEGIN_EXT && busy_out !== 1'b0 && n < 300) begin
         @(posedge clk_in);
         n++;
      end
      if (n >= 300) chk("busy", 0, 1);
   endtask : op

   task automatic fwr(input int a);
      @(posedge clk_in);
      fw_addr_in <= a[5:0];
      repeat (3) @(posedge clk_in);
      #1 chk("fw_rdata", pm[a], fw_rdata_out);
   endtask : fwr

   always @(posedge clk_in) begin
      if (rd_valid_out === 1'b1) begin
         ma = q.pop_front();
         me = q.pop_front();
         chk("img_addr", 2 * ma, img_addr_out);
         chk("img_word", me[13:0], {img_hi_out, img_lo_out});
      end
   end

   initial begin
      repeat (60000) @(posedge clk_in);
      bad_count++;
      close_out();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      frl_word_t cal;
      void'($urandom(32'h947e3445));
      foreach (lat[k]) lat[k] = 14'h3fff;
      foreach (cfg[k]) cfg[k] = 14'h3fff;
      repeat (4) @(posedge clk_in);
      reset_in <= 1'b0;
      op(FRL_CMD_BULK_ERASE, 0);
      cal = frl_word_t'($urandom);
      op(FRL_CMD_LOAD_CFG, 0);
      repeat (9) op(FRL_CMD_INC_ADDR, 0);
      op(FRL_CMD_LOAD_DATA, cal);
      op(FRL_CMD_BEGIN_INT, 0);
      // Start mid row and overrun by one word
      op(FRL_CMD_RESET_ADDR, 0);
      repeat (2) op(FRL_CMD_INC_ADDR, 0);
      for (int i = 0; i < 33; i++) begin
         op(FRL_CMD_LOAD_DATA, frl_word_t'($urandom));
         if (i < 32) op(FRL_CMD_INC_ADDR, 0);
      end
      op(FRL_CMD_BEGIN_INT, 0);
      op(FRL_CMD_RESET_ADDR, 0);
      for (int i = 0; i < 32; i++) begin
         op(FRL_CMD_LOAD_DATA, frl_word_t'($urandom));
         if (i < 31) op(FRL_CMD_INC_ADDR, 0);
      end
      op(FRL_CMD_BEGIN_EXT, 0);
      op(FRL_CMD_END_EXT, 0);
      @(posedge clk_in) cks_clear_in <= 1'b1;
      @(posedge clk_in) cks_clear_in <= 1'b0;
      cks = '0;
      cfs = '0;
      pid = '0;
      op(FRL_CMD_RESET_ADDR, 0);
      for (int i = 0; i < 64; i++) begin
         op(FRL_CMD_READ, 0);
         op(FRL_CMD_INC_ADDR, 0);
      end
      // Random user IDs feed the protected checksum
      op(FRL_CMD_LOAD_CFG, 0);
      for (int i = 0; i < 4; i++) begin
         op(FRL_CMD_LOAD_DATA, frl_word_t'($urandom));
         op(FRL_CMD_BEGIN_INT, 0);
         op(FRL_CMD_READ, 0);
         op(FRL_CMD_INC_ADDR, 0);
      end
      repeat (3) op(FRL_CMD_INC_ADDR, 0);
      op(FRL_CMD_READ, 0);
      op(FRL_CMD_INC_ADDR, 0);
      op(FRL_CMD_READ, 0);
      repeat (4) @(posedge clk_in);
      chk("cks_prot", 16'(pid + cfs), cks_prot_out);
      cks += cfs;
      chk("cks_open", cks, cks_open_out);
      chk("uid_words", {10'h0, cks[15:12], 10'h0, cks[11:8], 10'h0, cks[7:4], 10'h0, cks[3:0]},
         uid_words_out);
      op(FRL_CMD_LOAD_DATA, 0);
      op(FRL_CMD_BEGIN_EXT, 0);
      op(FRL_CMD_END_EXT, 0);
      op(FRL_CMD_READ, 0);
      op(FRL_CMD_LOAD_CFG, 0);
      repeat (6) op(FRL_CMD_INC_ADDR, 0);
      for (int i = 0; i < 2; i++) begin
         exp_id <= i ? cfg[6] : frl_word_t'($urandom);
         op(FRL_CMD_READ, 0);
         chk("id_mismatch", exp_id != cfg[6], id_mismatch_out);
      end
      op(FRL_CMD_LOAD_CFG, 0);
      repeat (7) op(FRL_CMD_INC_ADDR, 0);
      op(FRL_CMD_LOAD_DATA, 14'h3f7f);
      op(FRL_CMD_BEGIN_INT, 0);
      op(FRL_CMD_READ, 0);
      chk("protected", 1, protected_out);
      op(FRL_CMD_RESET_ADDR, 0);
      op(FRL_CMD_READ, 0);
      op(FRL_CMD_LOAD_DATA, 14'h0155);
      op(FRL_CMD_BEGIN_INT, 0);
      op(FRL_CMD_ROW_ERASE, 0);
      fwr(0);
      fwr(40);
      @(posedge clk_in);
      fw_we_in <= 1'b1;
      fw_addr_in <= 6'h05;
      fw_wdata_in <= 14'h2a5a;
      @(posedge clk_in) fw_we_in <= 1'b0;
      pm[5] = 14'h2a5a;
      fwr(5);
      op(FRL_CMD_BULK_ERASE, 0);
      chk("protected", 0, protected_out);
      fwr(0);
      op(FRL_CMD_LOAD_CFG, 0);
      op(FRL_CMD_ROW_ERASE, 0);
      op(FRL_CMD_READ, 0);
      repeat (9) op(FRL_CMD_INC_ADDR, 0);
      op(FRL_CMD_READ, 0);
      repeat (4) @(posedge clk_in);
      chk("reads_left", 0, q.size());
      close_out();
   end
endmodule : test_flash_row_latch_write_and_code_protect
